// ---- fpcm_defines.svh ----
// Register map, field positions, reset values and timing for the clock mode control
`ifndef FPCM_DEFINES_SVH
`define FPCM_DEFINES_SVH
`define FPCM_OFS_CTRL2 8'h00
`define FPCM_OFS_CTRL3 8'h04
`define FPCM_OFS_STAT 8'h08
`define FPCM_OFS_MODE 8'h0c
`define FPCM_CTRL2_RST 8'h04
`define FPCM_CTRL3_RST 8'h01
`define FPCM_CTRL3_MASK 8'hef
`define FPCM_B_IRQEN 7
`define FPCM_B_PLLSEL 6
`define FPCM_B_MONEN 5
`define FPCM_F_VCO 3:0
`define FPCM_F_CLKSEL 7:6
`define FPCM_F_REFDIV 5:3
`define FPCM_B_INTREF 2
`define FPCM_B_LOWPWR 1
`define FPCM_B_EXTOUT 0
`define FPCM_B_LOCKLOSS 7
`define FPCM_VCO_MAXCODE 4'ha
`define FPCM_VCO_MAXMUL 6'h28
`define FPCM_VCO_RSVMUL 6'h04
`define FPCM_FLL_MUL 11'h400
`define FPCM_CLK_MHZ 40
`define FPCM_SETTLE_NS 100
`define FPCM_SETTLE_CYC ((`FPCM_SETTLE_NS * `FPCM_CLK_MHZ + 999) / 1000)
`define FPCM_SRC_FLL 2'h0
`define FPCM_SRC_INT 2'h1
`define FPCM_SRC_EXT 2'h2
`define FPCM_SRC_PLL 2'h3
`define FPCM_DBG_FLL 2'h0
`define FPCM_DBG_OSC2 2'h1
`define FPCM_DBG_OFF 2'h2
`endif

// ---- fpcm_pkg.sv ----
// Types shared by the clock mode control
`default_nettype none
package fpcm_pkg;
	typedef enum logic [3:0] {
		M_FLL_ENG_INT, M_FLL_ENG_EXT, M_FLL_BYP_INT, M_FLL_BYP_EXT,
		M_PLL_ENG_EXT, M_PLL_BYP_EXT, M_LPWR_BYP_INT, M_LPWR_BYP_EXT, M_STOPPED
	} fpcm_mode_e;
	typedef logic [1:0] fpcm_src_t;
endpackage
`default_nettype wire

// ---- fpcm_mode_if.sv ----
// Control and status bundle between register file and mode machine
`timescale 1ns/1ps
`default_nettype none
interface fpcm_mode_if;
	logic [1:0] clkSel;
	logic [2:0] refDiv;
	logic intRefSel;
	logic pllSel;
	logic lowPower;
	logic dbgActive;
	logic stopReq;
	logic extRefOk;
	logic locked;
	fpcm_pkg::fpcm_mode_e mode;
	fpcm_pkg::fpcm_src_t clkStatus;
	logic pllStatus;
	logic intRefStatus;
	fpcm_pkg::fpcm_src_t debugClkSel;
	logic fllEnable;
	logic pllEnable;
	logic openLoopOsc;
	modport ctrl (output clkSel, refDiv, intRefSel, pllSel, lowPower, dbgActive, stopReq,
		extRefOk, locked, input mode, clkStatus, pllStatus, intRefStatus, debugClkSel,
		fllEnable, pllEnable, openLoopOsc);
	modport fsm (input clkSel, refDiv, intRefSel, pllSel, lowPower, dbgActive, stopReq,
		extRefOk, locked, output mode, clkStatus, pllStatus, intRefStatus, debugClkSel,
		fllEnable, pllEnable, openLoopOsc);
endinterface
`default_nettype wire

// ---- fpcm_sync.sv ----
// Two-stage synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module fpcm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// Refused at elaboration, not at run time
	if (W < 1) begin : g_bad_w
		$error("fpcm_sync: width must be at least one");
	end
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_r;
		logic stab_r;
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				meta_r <= 1'b0;
				stab_r <= 1'b0;
			end else begin
				meta_r <= din[i];
				stab_r <= meta_r;
			end
		end
		assign dout[i] = stab_r;
	end
endmodule
`default_nettype wire

// ---- fpcm_mode_fsm.sv ----
// Mode state machine, clock switch settling and loop enables
`timescale 1ns/1ps
`default_nettype none
`include "fpcm_defines.svh"
module fpcm_mode_fsm #(
	parameter int SETTLE = `FPCM_SETTLE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Controls in, state out
	fpcm_mode_if.fsm m
);
	// Settle counter is eight bits wide
	if (SETTLE < 1 || SETTLE > 255) begin : g_bad_settle
		$error("fpcm_mode_fsm: SETTLE out of 1..255");
	end

	fpcm_pkg::fpcm_mode_e mode_r;
	fpcm_pkg::fpcm_mode_e tgt;
	fpcm_pkg::fpcm_src_t wantSrc;
	logic srcOk;
	logic [3:0] stat_r;
	logic [7:0] cnt_r;
	logic [1:0] dbgSel_r;
	logic fllEn_r;
	logic pllEn_r;
	logic osc_r;

	function automatic logic pairOk(fpcm_pkg::fpcm_mode_e a, fpcm_pkg::fpcm_mode_e b);
		case (a)
			fpcm_pkg::M_FLL_ENG_INT: pairOk = b inside {fpcm_pkg::M_FLL_ENG_EXT,
				fpcm_pkg::M_FLL_BYP_INT, fpcm_pkg::M_FLL_BYP_EXT};
			fpcm_pkg::M_FLL_ENG_EXT: pairOk = b inside {fpcm_pkg::M_FLL_BYP_INT,
				fpcm_pkg::M_FLL_BYP_EXT};
			fpcm_pkg::M_FLL_BYP_INT: pairOk = b inside {fpcm_pkg::M_LPWR_BYP_INT,
				fpcm_pkg::M_FLL_BYP_EXT};
			fpcm_pkg::M_FLL_BYP_EXT: pairOk = b inside {fpcm_pkg::M_LPWR_BYP_EXT,
				fpcm_pkg::M_PLL_BYP_EXT};
			fpcm_pkg::M_PLL_BYP_EXT: pairOk = b inside {fpcm_pkg::M_LPWR_BYP_EXT,
				fpcm_pkg::M_PLL_ENG_EXT};
			default: pairOk = 1'b0;
		endcase
	endfunction

	function automatic logic moveOk(fpcm_pkg::fpcm_mode_e a, fpcm_pkg::fpcm_mode_e b);
		moveOk = (a == b) || pairOk(a, b) || pairOk(b, a);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Target decode from control bits; inconsistent settings hold the mode
	always_comb begin
		tgt = mode_r;
		unique case (m.clkSel)
			2'h0: begin
				if (m.intRefSel && !m.pllSel && m.refDiv == 3'h0) begin
					tgt = fpcm_pkg::M_FLL_ENG_INT;
				end else if (!m.intRefSel) begin
					tgt = m.pllSel ? fpcm_pkg::M_PLL_ENG_EXT
						: fpcm_pkg::M_FLL_ENG_EXT;
				end
			end
			2'h1: begin
				if (m.intRefSel && !m.pllSel) begin
					if (m.lowPower && !m.dbgActive) begin
						tgt = fpcm_pkg::M_LPWR_BYP_INT;
					end else if (m.refDiv == 3'h0) begin
						tgt = fpcm_pkg::M_FLL_BYP_INT;
					end
				end
			end
			2'h2: begin
				if (!m.intRefSel) begin
					if (m.lowPower && !m.dbgActive) begin
						tgt = fpcm_pkg::M_LPWR_BYP_EXT;
					end else begin
						// No range check: an over-range FLL reference is tolerated
						tgt = m.pllSel ? fpcm_pkg::M_PLL_BYP_EXT
							: fpcm_pkg::M_FLL_BYP_EXT;
					end
				end
			end
			2'h3: tgt = mode_r;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= fpcm_pkg::M_FLL_ENG_INT;
		end else if (m.stopReq) begin
			mode_r <= fpcm_pkg::M_STOPPED;
		end else if (mode_r == fpcm_pkg::M_STOPPED || moveOk(mode_r, tgt)) begin
			mode_r <= tgt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock source per mode; status moves only once the new source settled
	always_comb begin
		unique case (mode_r)
			fpcm_pkg::M_FLL_ENG_INT, fpcm_pkg::M_FLL_ENG_EXT: wantSrc = `FPCM_SRC_FLL;
			fpcm_pkg::M_FLL_BYP_INT, fpcm_pkg::M_LPWR_BYP_INT: wantSrc = `FPCM_SRC_INT;
			fpcm_pkg::M_PLL_ENG_EXT: wantSrc = `FPCM_SRC_PLL;
			fpcm_pkg::M_STOPPED: wantSrc = stat_r[3:2];
			default: wantSrc = `FPCM_SRC_EXT;
		endcase
	end
	assign srcOk = (wantSrc == `FPCM_SRC_EXT) ? m.extRefOk
		: (wantSrc == `FPCM_SRC_PLL) ? m.locked : 1'b1;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stat_r <= 4'h1;
			cnt_r <= 8'h00;
		end else if ({wantSrc, m.pllSel, m.intRefSel} == stat_r || !srcOk) begin
			// Unavailable source keeps the previous clock selected
			cnt_r <= 8'h00;
		end else if (cnt_r == 8'(SETTLE - 1)) begin
			stat_r <= {wantSrc, m.pllSel, m.intRefSel};
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Loop enables and debug clock choice
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fllEn_r <= 1'b1;
			pllEn_r <= 1'b0;
			osc_r <= 1'b0;
			dbgSel_r <= `FPCM_DBG_FLL;
		end else begin
			fllEn_r <= mode_r inside {fpcm_pkg::M_FLL_ENG_INT, fpcm_pkg::M_FLL_ENG_EXT,
				fpcm_pkg::M_FLL_BYP_INT, fpcm_pkg::M_FLL_BYP_EXT};
			pllEn_r <= mode_r inside {fpcm_pkg::M_PLL_ENG_EXT,
				fpcm_pkg::M_PLL_BYP_EXT};
			osc_r <= (mode_r inside {fpcm_pkg::M_PLL_ENG_EXT, fpcm_pkg::M_PLL_BYP_EXT})
				&& m.dbgActive;
			if (mode_r inside {fpcm_pkg::M_PLL_ENG_EXT, fpcm_pkg::M_PLL_BYP_EXT}) begin
				dbgSel_r <= m.dbgActive ? `FPCM_DBG_OSC2 : `FPCM_DBG_OFF;
			end else if (mode_r inside {fpcm_pkg::M_LPWR_BYP_INT,
				fpcm_pkg::M_LPWR_BYP_EXT, fpcm_pkg::M_STOPPED}) begin
				dbgSel_r <= `FPCM_DBG_OFF;
			end else begin
				dbgSel_r <= `FPCM_DBG_FLL;
			end
		end
	end

	assign m.mode = mode_r;
	assign m.clkStatus = stat_r[3:2];
	assign m.pllStatus = stat_r[1];
	assign m.intRefStatus = stat_r[0];
	assign m.debugClkSel = dbgSel_r;
	assign m.fllEnable = fllEn_r;
	assign m.pllEnable = pllEn_r;
	assign m.openLoopOsc = osc_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_loops_exclusive: assert property (!(fllEn_r && pllEn_r))
		else $error("FLL and PLL enabled together");
	a_mode_path: assert property ((mode_r != $past(mode_r) && $past(mode_r) !=
		fpcm_pkg::M_STOPPED && mode_r != fpcm_pkg::M_STOPPED)
		|-> moveOk($past(mode_r), mode_r))
		else $error("Mode moved along a forbidden transition");
	a_status_settle: assert property ($changed(stat_r) |->
		$past(cnt_r) == 8'(SETTLE - 1) && $past(srcOk))
		else $error("Clock status changed before switch settled");
	a_lpwr_loops_off: assert property ((mode_r == fpcm_pkg::M_LPWR_BYP_INT)
		|=> !fllEn_r && !pllEn_r)
		else $error("Loop running in low power internal mode");
endmodule
`default_nettype wire

// ---- fpcm_clock_mode_ctrl.sv ----
// Clock mode control: APB register file, lock-loss and monitor logic, mode machine
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fpcm_defines.svh"
module fpcm_clock_mode_ctrl #(
	parameter int ADDR_W = 8,
	parameter int SETTLE = `FPCM_SETTLE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Loop, oscillator, debug and stop indications, asynchronous
	input wire logic lockLostIn,
	input wire logic lockedIn,
	input wire logic extClkLostIn,
	input wire logic extRefOkIn,
	input wire logic dbgActiveIn,
	input wire logic stopIn,
	// Requests
	output logic irqReq,
	output logic resetReq,
	// Clock steering
	output logic [1:0] mainClkSel,
	output logic [1:0] debugClkSel,
	output logic fllEnable,
	output logic pllEnable,
	output logic openLoopOsc,
	output logic [2:0] refDivider,
	output logic intRefSel,
	output logic extRefOutEn,
	output logic [5:0] pllMultiplier,
	output logic [10:0] fllMultiplier
);
	// Decode reads the low address byte, so narrower buses cannot be served
	if (ADDR_W < 8) begin : g_bad_addr
		$error("fpcm_clock_mode_ctrl: ADDR_W too narrow for map");
	end

	fpcm_mode_if mif ();

	logic [5:0] syncOut;
	logic lockLostS;
	logic lockedS;
	logic extLostS;
	logic extOkS;
	logic dbgS;
	logic stopS;
	logic lockLostD_r;
	logic lockRise;
	logic [7:0] ctrl2_r;
	logic [7:0] ctrl3_r;
	logic sticky_r;
	logic irqReq_r;
	logic resetReq_r;
	logic [5:0] pllMult_r;
	logic [10:0] fllMult_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [31:0] rdMux;
	logic mapped;
	logic access;
	logic done;
	logic wrEn;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	fpcm_sync #(
		.W(6)
	) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.din({lockLostIn, lockedIn, extClkLostIn, extRefOkIn, dbgActiveIn, stopIn}),
		.dout(syncOut)
	);
	assign {lockLostS, lockedS, extLostS, extOkS, dbgS, stopS} = syncOut;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lockLostD_r <= 1'b0;
		end else begin
			lockLostD_r <= lockLostS;
		end
	end
	assign lockRise = lockLostS && !lockLostD_r;

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, answer registered
	assign access = psel && penable;
	assign done = access && pready_r;
	assign wrEn = done && pwrite && !pslverr_r;

	always_comb begin
		mapped = 1'b1;
		rdMux = 32'h0000_0000;
		case (paddr[7:0])
			`FPCM_OFS_CTRL2: rdMux = {24'h00_0000, ctrl2_r};
			`FPCM_OFS_CTRL3: rdMux = {24'h00_0000, ctrl3_r};
			`FPCM_OFS_STAT: rdMux = {24'h00_0000, sticky_r, lockedS, mif.pllStatus,
				mif.intRefStatus, mif.clkStatus, 2'h0};
			`FPCM_OFS_MODE: rdMux = {28'h000_0000, mif.mode};
			default: mapped = 1'b0;
		endcase
		if (ADDR_W > 8 && paddr[ADDR_W-1:0] > ADDR_W'(8'hff)) begin
			mapped = 1'b0;
		end
		if (!mapped) begin
			rdMux = 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (access && !pready_r) begin
			pready_r <= 1'b1;
			pslverr_r <= !mapped;
			prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl2_r <= `FPCM_CTRL2_RST;
		end else if (wrEn && paddr[7:0] == `FPCM_OFS_CTRL2) begin
			ctrl2_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl3_r <= `FPCM_CTRL3_RST;
		end else if (wrEn && paddr[7:0] == `FPCM_OFS_CTRL3) begin
			// Monitor use is left to software; it is not gated by mode here
			ctrl3_r <= pwdata[7:0] & `FPCM_CTRL3_MASK;
		end
	end

	// A lock-loss edge while a loop is enabled wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sticky_r <= 1'b0;
		end else if (lockRise && (mif.fllEnable || mif.pllEnable)) begin
			sticky_r <= 1'b1;
		end else if (wrEn && paddr[7:0] == `FPCM_OFS_STAT
			&& pwdata[`FPCM_B_LOCKLOSS]) begin
			sticky_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Requests and multipliers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irqReq_r <= 1'b0;
			resetReq_r <= 1'b0;
		end else begin
			irqReq_r <= ctrl3_r[`FPCM_B_IRQEN] && sticky_r;
			resetReq_r <= ctrl3_r[`FPCM_B_MONEN] && extLostS;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pllMult_r <= 6'h04;
			fllMult_r <= `FPCM_FLL_MUL;
		end else begin
			if (ctrl3_r[`FPCM_F_VCO] == 4'h0) begin
				pllMult_r <= `FPCM_VCO_RSVMUL;
			end else if (ctrl3_r[`FPCM_F_VCO] > `FPCM_VCO_MAXCODE) begin
				pllMult_r <= `FPCM_VCO_MAXMUL;
			end else begin
				pllMult_r <= {ctrl3_r[`FPCM_F_VCO], 2'h0};
			end
			fllMult_r <= `FPCM_FLL_MUL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode machine
	assign mif.clkSel = ctrl2_r[`FPCM_F_CLKSEL];
	assign mif.refDiv = ctrl2_r[`FPCM_F_REFDIV];
	assign mif.intRefSel = ctrl2_r[`FPCM_B_INTREF];
	assign mif.lowPower = ctrl2_r[`FPCM_B_LOWPWR];
	assign mif.pllSel = ctrl3_r[`FPCM_B_PLLSEL];
	assign mif.dbgActive = dbgS;
	assign mif.stopReq = stopS;
	assign mif.extRefOk = extOkS;
	assign mif.locked = lockedS;

	fpcm_mode_fsm #(
		.SETTLE(SETTLE)
	) u_fsm (
		.mclk(mclk),
		.rstn(rstn),
		.m(mif.fsm)
	);

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irqReq = irqReq_r;
	assign resetReq = resetReq_r;
	assign mainClkSel = mif.clkStatus;
	assign debugClkSel = mif.debugClkSel;
	assign fllEnable = mif.fllEnable;
	assign pllEnable = mif.pllEnable;
	assign openLoopOsc = mif.openLoopOsc;
	assign refDivider = ctrl2_r[`FPCM_F_REFDIV];
	assign intRefSel = ctrl2_r[`FPCM_B_INTREF];
	assign extRefOutEn = ctrl2_r[`FPCM_B_EXTOUT];
	assign pllMultiplier = pllMult_r;
	assign fllMultiplier = fllMult_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_irq_raise: assert property ((ctrl3_r[7] && sticky_r) |=> irqReq_r)
		else $error("Lock-loss interrupt not raised");
	a_irq_masked: assert property (!ctrl3_r[7] |=> !irqReq_r)
		else $error("Interrupt raised while disabled");
	a_sticky_hold: assert property ((sticky_r && !(wrEn && paddr[7:0] ==
		`FPCM_OFS_STAT && pwdata[7])) |=> sticky_r)
		else $error("Lock-loss flag cleared without write of one");
	a_sticky_clear: assert property ((sticky_r && wrEn && paddr[7:0] ==
		`FPCM_OFS_STAT && pwdata[7] && !lockRise) |=> !sticky_r)
		else $error("Lock-loss flag not cleared by write of one");
	a_monitor_reset: assert property ((ctrl3_r[5] && extLostS) |=> resetReq_r)
		else $error("Clock loss did not request reset");
	a_monitor_off: assert property (!ctrl3_r[5] |=> !resetReq_r)
		else $error("Reset requested with monitor disabled");
	a_vco_scale: assert property ((ctrl3_r[3:0] != 4'h0 && ctrl3_r[3:0] <= 4'ha)
		|=> pllMult_r == {$past(ctrl3_r[3:0]), 2'h0})
		else $error("PLL multiplier does not match VCO code");
	a_vco_reserved: assert property ((ctrl3_r[3:0] > 4'ha) |=> pllMult_r == 6'h28)
		else $error("Reserved VCO code not treated as forty");
	// Counter instead of a repetition, so any legal SETTLE is covered
	logic [8:0] peeCnt_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			peeCnt_r <= 9'h000;
		end else if (mif.mode != fpcm_pkg::M_PLL_ENG_EXT || !lockedS) begin
			peeCnt_r <= 9'h000;
		end else if (peeCnt_r != 9'h1ff) begin
			peeCnt_r <= peeCnt_r + 9'h001;
		end
	end
	a_pll_main: assert property ((peeCnt_r > 9'(SETTLE)) |-> mainClkSel == `FPCM_SRC_PLL)
		else $error("Main clock not from PLL in PLL engaged mode");
endmodule
`default_nettype wire

// ---- fpcm_ext_osc.sv ----
// Model of the external oscillator and loop lock detectors
`timescale 1ns/1ps
`default_nettype none
module fpcm_ext_osc #(
	parameter int START = 8,
	parameter int LOCK = 10
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Bench commands
	input wire logic runOsc,
	input wire logic dropLock,
	// Loop enables from the block
	input wire logic fllEnable,
	input wire logic pllEnable,
	// Indications to the block
	output logic extRefOkIn,
	output logic extClkLostIn,
	output logic lockedIn,
	output logic lockLostIn
);
	int oscCnt;
	int lockCnt;
	logic wasRun;
	logic [1:0] loopsR;
	////////////////////////////////////////////////////////////////////////////
	// Crystal is not usable until its start-up count has run out
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			oscCnt <= 0;
			wasRun <= 1'b0;
		end else begin
			oscCnt <= !runOsc ? 0 : (oscCnt < START) ? oscCnt + 1 : oscCnt;
			wasRun <= wasRun | runOsc;
		end
	end
	assign extRefOkIn = (oscCnt == START);
	assign extClkLostIn = wasRun && !runOsc;
	////////////////////////////////////////////////////////////////////////////
	// Relock from scratch whenever the running loop changes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lockCnt <= 0;
			loopsR <= 2'h0;
		end else begin
			loopsR <= {pllEnable, fllEnable};
			if ({pllEnable, fllEnable} != loopsR || dropLock || loopsR == 2'h0) begin
				lockCnt <= 0;
			end else if (lockCnt < LOCK) begin
				lockCnt <= lockCnt + 1;
			end
		end
	end
	assign lockedIn = (lockCnt == LOCK);
	assign lockLostIn = dropLock;
endmodule
`default_nettype wire

// ---- fpcm_clock_mode_ctrl_tb.sv ----
// Self-checking bench for the clock mode control
`timescale 1ns/1ps
`default_nettype none
`include "fpcm_defines.svh"
module fpcm_clock_mode_ctrl_tb;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic dbgActive = 1'b0;
	logic runOsc = 1'b0;
	logic stopIn = 1'b0;
	logic dropLock = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, lockLost, locked, extLost, extOk;
	logic irqReq, resetReq, fllEnable, pllEnable, openLoopOsc, intRefSel, extRefOutEn;
	logic [1:0] mainClkSel, debugClkSel;
	logic [2:0] refDivider;
	logic [5:0] pllMultiplier;
	logic [10:0] fllMultiplier;
	int error_cnt = 0;
	int tests_run = 0;
	always #12.5 mclk = ~mclk;
	fpcm_clock_mode_ctrl #(.ADDR_W(8), .SETTLE(4)) i_dut (.mclk(mclk), .rstn(rstn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lockLostIn(lockLost),
		.lockedIn(locked), .extClkLostIn(extLost), .extRefOkIn(extOk), .dbgActiveIn(dbgActive),
		.stopIn(stopIn), .irqReq(irqReq), .resetReq(resetReq), .mainClkSel(mainClkSel),
		.debugClkSel(debugClkSel), .fllEnable(fllEnable), .pllEnable(pllEnable),
		.openLoopOsc(openLoopOsc), .refDivider(refDivider), .intRefSel(intRefSel),
		.extRefOutEn(extRefOutEn),
		.pllMultiplier(pllMultiplier), .fllMultiplier(fllMultiplier));
	fpcm_ext_osc i_osc (.mclk(mclk), .rstn(rstn), .runOsc(runOsc), .dropLock(dropLock),
		.fllEnable(fllEnable), .pllEnable(pllEnable), .extRefOkIn(extOk),
		.extClkLostIn(extLost), .lockedIn(locked), .lockLostIn(lockLost));
	////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask
	task automatic waitMode(input logic [3:0] exp);
		int n;
		n = 0;
		do begin
			apb(1'b0, `FPCM_OFS_MODE, 32'h0);
			n++;
		end while (rd[3:0] !== exp && n < 40);
		chk("mode", rd, 32'(exp));
		if (rd[3:0] !== exp) summarize();
	endtask
	task automatic waitSel(input logic [1:0] exp);
		int n;
		n = 0;
		while (mainClkSel !== exp && n < 60) begin
			@(posedge mclk);
			n++;
		end
		chk("mainClkSel", 32'(mainClkSel), 32'(exp));
		if (mainClkSel !== exp) summarize();
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Runaway guard
	initial begin
		repeat (50000) @(posedge mclk);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		runOsc <= 1'b1;
		rdChk("ctrl3", `FPCM_OFS_CTRL3, 32'h01);
		rdChk("ctrl2", `FPCM_OFS_CTRL2, 32'h04);
		chk("intRef", 32'(intRefSel), 32'h1);
		waitMode(4'h0);
		chk("fllMul", 32'(fllMultiplier), 32'h400);
		chk("pllEn", 32'(pllEnable), 32'h0);
		chk("irq", 32'(irqReq), 32'h0);
		waitSel(2'h0);
		wr(`FPCM_OFS_CTRL2, 32'h44);
		chk("mainClkSel", 32'(mainClkSel), 32'h0);
		waitMode(4'h2);
		waitSel(2'h1);
		// Low power internal, then debug forces the bypass mode back
		wr(`FPCM_OFS_CTRL2, 32'h46);
		waitMode(4'h6);
		chk("fllEn", 32'(fllEnable), 32'h0);
		chk("pllEn", 32'(pllEnable), 32'h0);
		dbgActive <= 1'b1;
		waitMode(4'h2);
		wr(`FPCM_OFS_CTRL2, 32'h44);
		dbgActive <= 1'b0;
		// Divider chosen for the FLL reference range
		wr(`FPCM_OFS_CTRL2, 32'h08);
		waitMode(4'h1);
		waitSel(2'h0);
		chk("refDiv", 32'(refDivider), 32'h1);
		// Monitor enabled while the external FLL engaged mode is active; it is not gated by mode
		wr(`FPCM_OFS_CTRL3, 32'h21);
		chk("resetReq", 32'(resetReq), 32'h0);
		runOsc <= 1'b0;
		repeat (5) @(posedge mclk);
		chk("resetReq", 32'(resetReq), 32'h1);
		wr(`FPCM_OFS_CTRL3, 32'h01);
		repeat (3) @(posedge mclk);
		chk("resetReq", 32'(resetReq), 32'h0);
		runOsc <= 1'b1;
		wr(`FPCM_OFS_CTRL2, 32'h89);
		waitMode(4'h3);
		waitSel(2'h2);
		chk("extOut", 32'(extRefOutEn), 32'h1);
		chk("fllEn", 32'(fllEnable), 32'h1);
		chk("pllEn", 32'(pllEnable), 32'h0);
		chk("dbgSel", 32'(debugClkSel), 32'h0);
		wr(`FPCM_OFS_CTRL3, 32'h41);
		wr(`FPCM_OFS_CTRL2, 32'h90);
		waitMode(4'h5);
		repeat (2) @(posedge mclk);
		chk("pllEn", 32'(pllEnable), 32'h1);
		chk("fllEn", 32'(fllEnable), 32'h0);
		for (int c = 0; c < 16; c++) begin
			wr(`FPCM_OFS_CTRL3, 32'h40 | c);
			repeat (3) @(posedge mclk);
			chk("pllMul", 32'(pllMultiplier), (c == 0) ? 32'h4 : (c > 10) ? 32'h28 : 32'(4 * c));
		end
		wr(`FPCM_OFS_CTRL2, 32'h10);
		waitMode(4'h4);
		waitSel(2'h3);
		dbgActive <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("dbgSel", 32'(debugClkSel), 32'h1);
		chk("openLoop", 32'(openLoopOsc), 32'h1);
		dbgActive <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("dbgSel", 32'(debugClkSel), 32'h2);
		chk("openLoop", 32'(openLoopOsc), 32'h0);
		chk("fllEn", 32'(fllEnable), 32'h0);
		// Engaged external with FLL has no direct path from the PLL engaged mode
		wr(`FPCM_OFS_CTRL3, 32'h0f);
		repeat (20) @(posedge mclk);
		rdChk("mode", `FPCM_OFS_MODE, 32'h4);
		dropLock <= 1'b1;
		repeat (6) @(posedge mclk);
		dropLock <= 1'b0;
		apb(1'b0, `FPCM_OFS_STAT, 32'h0);
		chk("lockLoss", 32'(rd[7]), 32'h1);
		chk("irq", 32'(irqReq), 32'h0);
		wr(`FPCM_OFS_CTRL3, 32'h8f);
		repeat (3) @(posedge mclk);
		chk("irq", 32'(irqReq), 32'h1);
		wr(`FPCM_OFS_STAT, 32'h00);
		apb(1'b0, `FPCM_OFS_STAT, 32'h0);
		chk("lockLoss", 32'(rd[7]), 32'h1);
		wr(`FPCM_OFS_STAT, 32'h80);
		apb(1'b0, `FPCM_OFS_STAT, 32'h0);
		chk("lockLoss", 32'(rd[7]), 32'h0);
		chk("irq", 32'(irqReq), 32'h0);
		wr(`FPCM_OFS_CTRL3, 32'hff);
		rdChk("ctrl3", `FPCM_OFS_CTRL3, 32'hef);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 32'(err), 32'h1);
		chk("unmapped", rd, 32'h0);
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		rdChk("ctrl3", `FPCM_OFS_CTRL3, 32'h01);
		waitMode(4'h0);
		// Stop from the reset mode M_FLL_ENG_INT, and back to the decoded target
		stopIn <= 1'b1;
		waitMode(4'h8);
		chk("fllEn", 32'(fllEnable), 32'h0);
		stopIn <= 1'b0;
		waitMode(4'h0);
		summarize();
	end
endmodule
`default_nettype wire
